// >>> adcsc_pkg.sv
// constants and types shared by the serial converter control block
package adcsc_pkg;
    localparam int RESULT_W = 12;
    localparam int CTRL_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam logic [4:0] CONV_CYCLES = 5'h10;
    localparam logic [4:0] FCNT_IDLE = 5'h00;
    localparam logic [4:0] TRACK_FIRST = 5'h01;
    localparam logic [4:0] HOLD_FIRST = 5'h04;
    localparam logic [4:0] RESULT_FIRST = 5'h05;
    localparam logic [3:0] CTRL_LAST_RISE = 4'h7;
    localparam logic [3:0] RCNT_IDLE = 4'h0;
    localparam int CHAN_SEL_LO_POS = 3;
    localparam int CHAN_SEL_MID_POS = 4;
    localparam int CHAN_SEL_HI_POS = 5;
    localparam logic CHAN_RESET = 1'b0;
    localparam logic [RESULT_W-1:0] RESULT_ZERO = 12'h000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam int SCLK_MAX_MHZ = 16;
    localparam int SYS_CLK_MHZ = 200;
    // rounded up so a host using this period never exceeds the serial clock limit
    localparam int SCLK_MIN_SYS_CYCLES = (SYS_CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;

    typedef enum logic [1:0] {
        PH_OFF,
        PH_TRACK,
        PH_HOLD,
        PH_GAP
    } adcsc_phase_e;
endpackage

// >>> adcsc_word_if.sv
// valid/ready word carrier between the control block and its result buffer
interface adcsc_word_if #(
    parameter int W = adcsc_pkg::RESULT_W
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> adcsc_buf2.sv
// two-entry result buffer with registered ready on the filling side
module adcsc_buf2 (
    input wire logic clk,
    input wire logic rst,
    adcsc_word_if.snk wr,
    adcsc_word_if.src rd
);
    logic [adcsc_pkg::RESULT_W-1:0] mem_r [adcsc_pkg::BUF_DEPTH];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic ready_r;
    wire push = wr.valid & ready_r;
    wire pop = rd.valid & rd.ready;

    assign wr.ready = ready_r;
    assign rd.valid = (cnt_r != 2'h0);
    assign rd.data = mem_r[rp_r];
    assign cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
            ready_r <= 1'b1;
        end else begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            cnt_r <= cnt_nxt;
            // registered from the next count so the source sees full in the same cycle it fills; never overfills
            ready_r <= (cnt_nxt != 2'h2);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= wr.data;
        end
    end
endmodule // adcsc_buf2

// >>> adcsc_top.sv
// serial control logic of a two-channel 12-bit sampling converter
// Overview of operation
// (RL1) control bits seven, six, two, one and zero have no effect on anything.
// (RL2) control bits five to three pick the input for the next track phase; bit 3 low is input one, high is input two, bit 5 ignored.
// (RL3) the host never sends bit 4 set; output is then undefined.
// (RL4) each result is an unsigned straight-binary 12-bit code.
// (RL5) the device is powered while frame select is low and powered down while it is high, except for the gap.
// (RL6) power-down starts after the 16th falling serial clock edge and lasts until the next 1st falling edge.
// (RL7) each conversion is exactly 16 serial clock cycles and conversions may run back to back.
// (RL8) with frame select low and the clock running, a new conversion follows each finished one without limit.
// (RL9) the host keeps the serial clock at or below 16 MHz, giving one sample per 16 clocks at most.
// (RL10) a host saving power keeps the clock fast and converts less often, leaving the device shut down between.
// (RL11) the control word is taken from the data input on the first 8 rising clock edges of each conversion.
// (RL12) the result leaves most significant bit first, starting on the 5th clock cycle.
// (RL13) the host frames each transfer with frame select and sends a multiple of 16 rising edges per frame; the testbench also sends one frame of 3.
// (RL14) the data output is released while frame select is high and driven only while it is low.
// (RL15) zeros are driven before the first result bit and after the last until the 16th cycle ends.
module adcsc_top (
    // system
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    // serial port
    input wire logic CS_N_IN,
    input wire logic SCLK_IN,
    input wire logic DIN_IN,
    output logic DOUT_OUT,
    output logic DOUT_OE_OUT,
    // converter core
    output logic POWER_ON_OUT,
    output logic TRACK_OUT,
    output logic CHANNEL_SEL_OUT,
    output logic SAMPLE_START_OUT,
    input wire logic [adcsc_pkg::RESULT_W-1:0] RESULT_IN,
    input wire logic RESULT_VALID_IN,
    output logic RESULT_READY_OUT
);
    logic sclk_d_r;
    logic cs_n_d_r;
    logic [4:0] fcnt_r;
    logic [4:0] fcnt_nxt;
    logic [3:0] rcnt_r;
    logic [adcsc_pkg::CTRL_W-1:0] ctrl_sh_r;
    logic [adcsc_pkg::CTRL_W-1:0] ctrl_word;
    logic pend_ch_r;
    logic word_ok_r;
    logic chan_r;
    adcsc_pkg::adcsc_phase_e phase_r;
    adcsc_pkg::adcsc_phase_e phase_nxt;
    logic [adcsc_pkg::RESULT_W-1:0] res_sh_r;
    logic [adcsc_pkg::RESULT_W-1:0] res_head;
    logic dout_r;
    logic dout_oe_r;
    logic power_r;
    logic track_r;
    logic start_r;

    adcsc_word_if res_in_if ();
    adcsc_word_if res_out_if ();

    adcsc_buf2 u_buf (
        .clk(SYS_CLK_IN),
        .rst(RESET_IN),
        .wr(res_in_if.snk),
        .rd(res_out_if.src)
    );

    // the core's result enters the buffer; the buffer's own flop is the ready port
    assign res_in_if.valid = RESULT_VALID_IN;
    assign res_in_if.data = RESULT_IN;

    wire frame_on = ~CS_N_IN;
    wire sclk_rise = SCLK_IN & ~sclk_d_r;
    wire sclk_fall = ~SCLK_IN & sclk_d_r;
    wire cs_fall = ~CS_N_IN & cs_n_d_r;
    // a frame start with the clock parked low counts as the first falling edge
    wire fall_ev = frame_on & (sclk_fall | (cs_fall & ~SCLK_IN));
    wire rise_ev = frame_on & sclk_rise;
    // back-to-back conversions: the 16th cycle rolls straight into the next
    wire conv_start = fall_ev & ((fcnt_r == adcsc_pkg::FCNT_IDLE)
        | (fcnt_r == adcsc_pkg::CONV_CYCLES)); // RL7 RL8
    wire ctrl_take = rise_ev & (rcnt_r <= adcsc_pkg::CTRL_LAST_RISE); // RL11
    wire ctrl_done = ctrl_take & (rcnt_r == adcsc_pkg::CTRL_LAST_RISE);
    wire load_res = fall_ev & (fcnt_nxt == adcsc_pkg::RESULT_FIRST); // RL12
    wire hold_go = fall_ev & (fcnt_nxt == adcsc_pkg::HOLD_FIRST);

    assign ctrl_word = {ctrl_sh_r[adcsc_pkg::CTRL_W-2:0], DIN_IN};
    // empty buffer at load time yields zeros; only the pop is acknowledged
    assign res_head = res_out_if.valid ? res_out_if.data : adcsc_pkg::RESULT_ZERO; // RL4
    assign res_out_if.ready = load_res;

    always_comb begin
        fcnt_nxt = fcnt_r;
        if (!frame_on) begin
            fcnt_nxt = adcsc_pkg::FCNT_IDLE;
        end else if (conv_start) begin
            fcnt_nxt = adcsc_pkg::TRACK_FIRST;
        end else if (fall_ev) begin
            fcnt_nxt = 5'(fcnt_r + 5'h01);
        end
    end

    always_comb begin
        phase_nxt = phase_r;
        if (!frame_on) begin
            phase_nxt = adcsc_pkg::PH_OFF; // RL5
        end else if (fall_ev) begin
            case (fcnt_nxt)
                adcsc_pkg::CONV_CYCLES: begin
                    phase_nxt = adcsc_pkg::PH_GAP; // RL6
                end
                default: begin
                    if (fcnt_nxt < adcsc_pkg::HOLD_FIRST) begin
                        phase_nxt = adcsc_pkg::PH_TRACK;
                    end else begin
                        phase_nxt = adcsc_pkg::PH_HOLD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            fcnt_r <= adcsc_pkg::FCNT_IDLE;
            phase_r <= adcsc_pkg::PH_OFF;
        end else begin
            sclk_d_r <= SCLK_IN;
            cs_n_d_r <= CS_N_IN;
            fcnt_r <= fcnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // control word capture; only bit 3 is kept, bits 7..4 and 2..0 are dropped
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rcnt_r <= adcsc_pkg::RCNT_IDLE;
            ctrl_sh_r <= adcsc_pkg::CTRL_RESET;
            pend_ch_r <= adcsc_pkg::CHAN_RESET;
            word_ok_r <= 1'b0;
        end else begin
            if (!frame_on || conv_start) begin
                rcnt_r <= adcsc_pkg::RCNT_IDLE;
            end else if (ctrl_take) begin
                rcnt_r <= 4'(rcnt_r + 4'h1);
            end
            if (ctrl_take) begin
                ctrl_sh_r <= ctrl_word; // RL11
            end
            if (ctrl_done) begin
                pend_ch_r <= ctrl_word[adcsc_pkg::CHAN_SEL_LO_POS]; // RL1 RL2 RL3
            end
            // a new word may finish after a conv_start only in a later cycle;
            // a complete word outlives frame select high and steers the next frame
            if (ctrl_done) begin
                word_ok_r <= 1'b1;
            end else if (conv_start) begin
                word_ok_r <= 1'b0;
            end
        end
    end

    // channel takes effect at the next track phase; stays across frames
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            chan_r <= adcsc_pkg::CHAN_RESET;
        end else if (conv_start && word_ok_r) begin
            chan_r <= pend_ch_r; // RL2
        end
    end

    // result shifter: zeros in cycles 1..4, then msb first, zeros beyond the lsb
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            res_sh_r <= adcsc_pkg::RESULT_ZERO;
            dout_r <= 1'b0;
        end else if (!frame_on) begin
            res_sh_r <= adcsc_pkg::RESULT_ZERO;
            dout_r <= 1'b0;
        end else if (load_res) begin
            res_sh_r <= {res_head[adcsc_pkg::RESULT_W-2:0], 1'b0}; // RL12
            dout_r <= res_head[adcsc_pkg::RESULT_W-1];
        end else if (fall_ev) begin
            if (fcnt_nxt < adcsc_pkg::RESULT_FIRST) begin
                res_sh_r <= adcsc_pkg::RESULT_ZERO;
                dout_r <= 1'b0; // RL15
            end else begin
                res_sh_r <= {res_sh_r[adcsc_pkg::RESULT_W-2:0], 1'b0};
                dout_r <= res_sh_r[adcsc_pkg::RESULT_W-1]; // RL15
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            dout_oe_r <= 1'b0;
            power_r <= 1'b0;
            track_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            dout_oe_r <= frame_on; // RL14
            power_r <= (phase_nxt == adcsc_pkg::PH_TRACK)
                | (phase_nxt == adcsc_pkg::PH_HOLD); // RL5 RL6
            track_r <= (phase_nxt == adcsc_pkg::PH_TRACK);
            start_r <= hold_go;
        end
    end

    assign DOUT_OUT = dout_r;
    assign DOUT_OE_OUT = dout_oe_r;
    assign POWER_ON_OUT = power_r;
    assign TRACK_OUT = track_r;
    assign CHANNEL_SEL_OUT = chan_r;
    assign SAMPLE_START_OUT = start_r;
    assign RESULT_READY_OUT = res_in_if.ready;
endmodule // adcsc_top

// >>> adcsc_monitor.sv
// assertion checker for the serial converter control block
module adcsc_monitor (
    // system
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    // serial port
    input wire logic CS_N_IN,
    input wire logic SCLK_IN,
    input wire logic DIN_IN,
    input wire logic DOUT_OUT,
    input wire logic DOUT_OE_OUT,
    // converter core
    input wire logic POWER_ON_OUT,
    input wire logic TRACK_OUT,
    input wire logic CHANNEL_SEL_OUT,
    input wire logic SAMPLE_START_OUT,
    input wire logic [adcsc_pkg::RESULT_W-1:0] RESULT_IN,
    input wire logic RESULT_VALID_IN,
    input wire logic RESULT_READY_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN);
    frame_off_a: assert property (CS_N_IN |=> !DOUT_OE_OUT && !POWER_ON_OUT)
        else $error("driver or power left on outside a frame");
    released_low_a: assert property (!DOUT_OE_OUT |-> !DOUT_OUT)
        else $error("data output active while released");
    track_zero_a: assert property (TRACK_OUT |-> !DOUT_OUT)
        else $error("data output not zero during track");
    track_power_a: assert property (TRACK_OUT |-> POWER_ON_OUT)
        else $error("track phase without power");
    power_track_a: assert property ($rose(POWER_ON_OUT) |-> TRACK_OUT)
        else $error("power up not at a track start");
    start_once_a: assert property (SAMPLE_START_OUT |=> !SAMPLE_START_OUT)
        else $error("sample start longer than one cycle");
    hold_start_a: assert property ($fell(TRACK_OUT) && !CS_N_IN |-> SAMPLE_START_OUT)
        else $error("hold entered without sample start");
    chan_move_a: assert property ($changed(CHANNEL_SEL_OUT) |-> $rose(TRACK_OUT))
        else $error("channel changed outside a conversion start");
endmodule // adcsc_monitor

bind adcsc_top adcsc_monitor u_mon (.*);

// >>> adcsc_core_model.sv
// behavioural converter core handing result words to the control block
module adcsc_core_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // requests
    input wire logic push_in,
    input wire logic [adcsc_pkg::RESULT_W-1:0] word_in,
    // result side
    input wire logic ready_in,
    output logic valid_out,
    output logic [adcsc_pkg::RESULT_W-1:0] data_out
);
    logic [adcsc_pkg::RESULT_W-1:0] q[$];
    // words wait here while the buffer refuses, so a stall drops nothing
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q.delete();
            valid_out <= 1'b0;
            data_out <= 12'h000;
        end else begin
            if (valid_out && ready_in) void'(q.pop_front());
            if (push_in) q.push_back(word_in);
            valid_out <= q.size() != 0;
            // idle bus flips each cycle so a stale word is never mistaken for live
            data_out <= (q.size() != 0) ? q[0] : ~data_out;
        end
    end
endmodule // adcsc_core_model

// >>> tb_top.sv
// self-checking testbench for the serial converter control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n = 1'b1;
    logic sclk = 1'b1;
    logic din = 1'b0;
    logic push = 1'b0;
    logic feed = 1'b0;
    logic [11:0] word = 12'h000;
    logic [11:0] core_data;
    logic core_valid, ready, dout, oe, pwr, trk, chan;
    logic ch_exp = 1'b0;
    logic pend = 1'b0;
    logic have = 1'b0;
    logic [11:0] expq[$];
    int n_errors = 0;
    int compares = 0;
    int seed = 32'h57fb;
    int cyc = 0;
    // serial clock half period in system cycles; a full period stays at or below 16 MHz
    localparam int HALF = (adcsc_pkg::SCLK_MIN_SYS_CYCLES + 1) / 2;
    always #2.5 clk = ~clk;
    adcsc_top dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk),
        .DIN_IN(din), .DOUT_OUT(dout), .DOUT_OE_OUT(oe), .POWER_ON_OUT(pwr), .TRACK_OUT(trk),
        .CHANNEL_SEL_OUT(chan), .SAMPLE_START_OUT(), .RESULT_IN(core_data),
        .RESULT_VALID_IN(core_valid), .RESULT_READY_OUT(ready));
    adcsc_core_model core (.clk_in(clk), .rst_in(rst), .push_in(push), .word_in(word),
        .ready_in(ready), .valid_out(core_valid), .data_out(core_data));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pushw(input logic [11:0] w);
        word <= w;
        push <= 1'b1;
        expq.push_back(w);
    endtask
    // one frame of ncyc serial cycles; lo parks the serial clock low before the frame
    task automatic frame(input int ncyc, input logic lo);
        logic [7:0] ctl;
        logic [15:0] d, p, t;
        int k;
        @(posedge clk);
        if (lo) sclk <= 1'b0; else cs_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (int c = 0; c < ncyc; c++) begin
            k = c % 16;
            if (k == 0) begin
                ctl = 8'($random(seed)) & 8'hEF;
                if (have) ch_exp = pend;
                have = 1'b0;
            end
            @(posedge clk);
            if (c == 0 && lo) cs_n <= 1'b0; else sclk <= 1'b0;
            din <= (k < 8) ? ctl[7 - k] : 1'($random(seed));
            repeat (HALF - 1) @(posedge clk);
            @(negedge clk);
            d = {d[14:0], dout};
            p = {p[14:0], pwr};
            t = {t[14:0], trk};
            if (k == 0) chk("channel", {15'h0, ch_exp}, {15'h0, chan});
            @(posedge clk);
            sclk <= 1'b1;
            if (k == 3 && feed) pushw(12'($random(seed)));
            if (k == 7) pend = ctl[3];
            if (k == 7) have = 1'b1;
            if (k == 15) begin
                chk("result", {4'h0, expq.pop_front()}, d);
                chk("power", 16'hFFFE, p);
                chk("track", 16'hE000, t);
            end
            @(posedge clk);
            push <= 1'b0;
            repeat (HALF - 2) @(posedge clk);
        end
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("released", 16'h0000, {13'h0, oe, dout, pwr});
    endtask
    task automatic results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("ready", 16'h0001, {15'h0, ready});
        // three words at once: buffer fills and the core must stall
        repeat (3) begin
            @(posedge clk);
            pushw(12'($random(seed)));
        end
        @(posedge clk);
        push <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("full", 16'h0000, {15'h0, ready});
        frame(48, 1'b0);
        chk("drained", 16'h0001, {15'h0, ready});
        feed = 1'b1;
        frame(3, 1'b1);
        repeat (12) frame(16 * (1 + (($random(seed) & 3) % 3)), 1'($random(seed)));
        results();
    end
endmodule // tb_top
